/* include/code_lock_defines.svh */
// constants for the code lock and verify encryption block
`ifndef CODE_LOCK_DEFINES_SVH
`define CODE_LOCK_DEFINES_SVH
`define CL_CODE_AW        15
`define CL_CODE_BYTES     32768
`define CL_ENC_AW         6
`define CL_ENC_BYTES      64
`define CL_SIG_BYTES      4
`define CL_ERASED_BYTE    8'hFF
`define CL_OFF_CTRL       12'h000
`define CL_OFF_STATUS     12'h004
`define CL_OFF_ADDR       12'h008
`define CL_OFF_DATA       12'h00C
`define CL_OFF_VERIFY     12'h010
`define CL_OFF_CPU_ADDR   12'h014
`define CL_OFF_CPU_DATA   12'h018
`define CL_OFF_SIG_BASE   12'h020
`define CL_CTRL_EPROM     0
`define CL_CTRL_EXT_EXEC  1
`define CL_CMD_PROG_CODE  3'd1
`define CL_CMD_PROG_ENC   3'd2
`define CL_CMD_PROG_LB1   3'd3
`define CL_CMD_PROG_LB2   3'd4
`define CL_CMD_PROG_LB3   3'd5
`define CL_CMD_ERASE      3'd6
`define CL_SIG0           8'hA5
`define CL_SIG1           8'h5A
`define CL_SIG2           8'h3C
`define CL_SIG3           8'hFF
`endif

/* include/code_lock_pkg.sv */
// types for the code lock and verify encryption block
package code_lock_pkg;
    typedef enum logic [3:0] {
        LEVEL_1 = 4'b0001,
        LEVEL_2 = 4'b0010,
        LEVEL_3 = 4'b0100,
        LEVEL_4 = 4'b1000
    } sec_level_t;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_ERASE = 3'b010,
        ST_DONE  = 3'b100
    } eng_state_t;
endpackage

/* hw/byte_mem.sv */
// byte memory with one write port and one read port, registered read data, contents not reset
`timescale 1ns/1ps
module byte_mem #(
    parameter int AW = 6
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [7:0]    wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [7:0]    rdata
);
    logic [7:0] cells [0:(1<<AW)-1];

    // contents are not reset; erase is done by the owner writing FF everywhere
    always_ff @(posedge clk) begin
        if (we) begin
            cells[waddr] <= wdata;
        end
        rdata <= cells[raddr];
    end
endmodule

/* hw/code_lock.sv */
// program memory protection: lock levels, verify encryption, apb access
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "code_lock_defines.svh"
// Functional notes
// - code, 64-byte encryption and 4-byte signature arrays
// - encryption bytes read all ones until programmed; here only after an erase, as the array is not reset
// - six address lines select the encryption byte
// - verify byte is code XNOR encryption byte
// - blank encryption array returns code unchanged
// - level 1: no locks, verify still encrypted
// - level 2: external table reads blocked internally
// - level 2+: access select latched at reset
// - eprom level 2+: programming refused
// - level 3: also verify read-out disabled
// - level 4: also external execution prevented
// - signature bytes fixed, never programmable
// - erase sets all cells and locks to ones
module code_lock
    import code_lock_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        external_access_select,
    input  wire logic        code_table_read_instruction,
    input  wire logic        fetch_external,
    output logic             external_access_latched,
    output logic             table_read_blocked,
    output logic             external_exec_blocked,
    output logic             verify_enabled
);
    // pin synchroniser; first stage read only by second
    logic       ea_s1;
    logic       ea_s2;
    logic       code_table_read_instruction_s1;
    logic       code_table_read_instruction_s2;
    logic       fext_s1;
    logic       fext_s2;
    // lock bits, 1 = unprogrammed
    logic       lock_bit_first;
    logic       lock_bit_second;
    logic       lock_bit_third;
    logic [1:0] ctrl;
    logic [`CL_CODE_AW-1:0] addr;
    logic [7:0] wbyte;
    logic       reset_seen;
    logic       ea_latch;
    eng_state_t state;
    logic [`CL_CODE_AW-1:0] erase_ptr;
    logic       busy_rd;
    logic [1:0] rd_wait;
    logic       refused;
    logic [`CL_CODE_AW-1:0] cpu_addr;

    // memories
    logic [7:0] code_rdata;
    logic [7:0] enc_rdata;

    function automatic logic [7:0] xnor_byte(input logic [7:0] a, input logic [7:0] b);
        return ~(a ^ b);
    endfunction

    // level decode: most restrictive programmed bit wins
    wire sec_level_t level = !lock_bit_third  ? LEVEL_4 :
                             !lock_bit_second ? LEVEL_3 :
                             !lock_bit_first  ? LEVEL_2 : LEVEL_1;
    wire lvl2_up = (level != LEVEL_1);
    wire lvl3_up = (level == LEVEL_3) || (level == LEVEL_4);
    wire lvl4    = (level == LEVEL_4);
    wire is_eprom = ctrl[`CL_CTRL_EPROM];
    wire prog_locked = is_eprom && lvl2_up;

    // apb decode
    wire setup   = psel && !penable;
    wire access  = psel && penable;
    wire wr_acc  = access && pwrite && pready;
    wire hit_ctrl   = (paddr == `CL_OFF_CTRL);
    wire hit_status = (paddr == `CL_OFF_STATUS);
    wire hit_addr   = (paddr == `CL_OFF_ADDR);
    wire hit_data   = (paddr == `CL_OFF_DATA);
    wire hit_verify = (paddr == `CL_OFF_VERIFY);
    wire hit_caddr  = (paddr == `CL_OFF_CPU_ADDR);
    wire hit_cdata  = (paddr == `CL_OFF_CPU_DATA);
    wire hit_sig    = (paddr[11:4] == `CL_OFF_SIG_BASE >> 4) && (paddr[3:2] <= 2'd3) && (paddr[1:0] == 2'd0);
    wire hit_any = hit_ctrl | hit_status | hit_addr | hit_data | hit_verify | hit_caddr | hit_cdata | hit_sig;
    wire mem_rd  = hit_verify | hit_cdata;
    wire [2:0] cmd = pwdata[10:8];
    wire cmd_wr  = wr_acc && hit_ctrl && (cmd != 3'd0) && (state == ST_IDLE);
    wire cmd_prog = (cmd == `CL_CMD_PROG_CODE) || (cmd == `CL_CMD_PROG_ENC) || (cmd == `CL_CMD_PROG_LB1) ||
                    (cmd == `CL_CMD_PROG_LB2) || (cmd == `CL_CMD_PROG_LB3);
    wire cmd_ok  = cmd_wr && !(cmd_prog && prog_locked);
    wire cmd_refused = cmd_wr && cmd_prog && prog_locked;

    // memory ports: erase writes all ones everywhere
    wire erasing  = (state == ST_ERASE);
    wire code_we  = erasing || (cmd_ok && cmd == `CL_CMD_PROG_CODE);
    wire enc_we   = (erasing && erase_ptr < `CL_ENC_BYTES) || (cmd_ok && cmd == `CL_CMD_PROG_ENC);
    wire [`CL_CODE_AW-1:0] code_waddr = erasing ? erase_ptr : addr;
    wire [`CL_ENC_AW-1:0]  enc_waddr  = erasing ? erase_ptr[`CL_ENC_AW-1:0] : addr[`CL_ENC_AW-1:0];
    wire [7:0] mem_wbyte = erasing ? `CL_ERASED_BYTE : wbyte;
    wire [`CL_CODE_AW-1:0] code_raddr = hit_cdata ? cpu_addr : addr;
    wire [`CL_ENC_AW-1:0]  enc_raddr  = addr[`CL_ENC_AW-1:0];

    byte_mem #(.AW(`CL_CODE_AW)) u_code (
        .clk   (clk),
        .we    (code_we),
        .waddr (code_waddr),
        .wdata (mem_wbyte),
        .raddr (code_raddr),
        .rdata (code_rdata)
    );

    byte_mem #(.AW(`CL_ENC_AW)) u_enc (
        .clk   (clk),
        .we    (enc_we),
        .waddr (enc_waddr),
        .wdata (mem_wbyte),
        .raddr (enc_raddr),
        .rdata (enc_rdata)
    );

    // verify path: encrypted byte, zero when read-out disabled
    wire [7:0] verify_byte = lvl3_up ? 8'h00 : xnor_byte(code_rdata, enc_rdata);
    // cpu table read from external memory: plain data, blocked from level 2
    logic code_table_read_instruction_s;
    logic fetch_ext_s;
    assign code_table_read_instruction_s = code_table_read_instruction_s2;
    assign fetch_ext_s = fext_s2;
    wire       ext_table = code_table_read_instruction_s && fetch_ext_s;
    wire [7:0] cpu_byte = (lvl2_up && fetch_ext_s) ? 8'h00 : code_rdata;

    // signature bytes are constants, writes have no path to them
    wire [7:0] sig_byte = (paddr[3:2] == 2'd0) ? `CL_SIG0 :
                          (paddr[3:2] == 2'd1) ? `CL_SIG1 :
                          (paddr[3:2] == 2'd2) ? `CL_SIG2 : `CL_SIG3;

    wire [31:0] status_word = {20'h00000, 1'b0, refused, (state != ST_IDLE), ea_latch,
                               level, 1'b0, lock_bit_third, lock_bit_second, lock_bit_first};
    wire [31:0] rd_mux = hit_ctrl   ? {30'h00000000, ctrl} :
                         hit_status ? status_word :
                         hit_addr   ? {17'h00000, addr} :
                         hit_data   ? {24'h000000, wbyte} :
                         hit_verify ? {24'h000000, verify_byte} :
                         hit_caddr  ? {17'h00000, cpu_addr} :
                         hit_cdata  ? {24'h000000, cpu_byte} :
                         hit_sig    ? {24'h000000, sig_byte} : 32'h00000000;

    // pin synchronisers
    always_ff @(posedge clk) begin
        ea_s1   <= external_access_select;
        ea_s2   <= ea_s1;
        code_table_read_instruction_s1 <= code_table_read_instruction;
        code_table_read_instruction_s2 <= code_table_read_instruction_s1;
        fext_s1 <= fetch_external;
        fext_s2 <= fext_s1;
    end

    // memory reads take two cycles: address registered in memory then data mux
    always_ff @(posedge clk) begin
        if (rst) begin
            pready  <= 1'b0;
            busy_rd <= 1'b0;
            rd_wait <= 2'd0;
        end else begin
            pready <= 1'b0;
            if (setup && !mem_rd) begin
                pready <= 1'b1;
            end else if (setup && mem_rd) begin
                busy_rd <= 1'b1;
                rd_wait <= 2'd1;
            end else if (busy_rd) begin
                if (rd_wait == 2'd0) begin
                    pready  <= 1'b1;
                    busy_rd <= 1'b0;
                end else begin
                    rd_wait <= rd_wait - 2'd1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            prdata  <= rd_mux;
            // refusals only hit the fast path, so the error pulses with the setup-driven pready
            pslverr <= setup && (!hit_any || (pwrite && hit_sig));
        end
    end

    // writable registers
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl     <= 2'b00;
            addr     <= '0;
            wbyte    <= 8'hFF;
            cpu_addr <= '0;
        end else if (wr_acc) begin
            if (hit_ctrl) begin
                ctrl <= pwdata[1:0];
            end
            if (hit_addr) begin
                addr <= pwdata[`CL_CODE_AW-1:0];
            end
            if (hit_data) begin
                wbyte <= pwdata[7:0];
            end
            if (hit_caddr) begin
                cpu_addr <= pwdata[`CL_CODE_AW-1:0];
            end
        end
    end

    // lock bits are non-volatile in silicon; here they start erased at reset
    always_ff @(posedge clk) begin
        if (rst) begin
            lock_bit_first  <= 1'b1;
            lock_bit_second <= 1'b1;
            lock_bit_third  <= 1'b1;
        end else if (state == ST_DONE) begin
            lock_bit_first  <= 1'b1;
            lock_bit_second <= 1'b1;
            lock_bit_third  <= 1'b1;
        end else if (cmd_ok) begin
            if (cmd == `CL_CMD_PROG_LB1) lock_bit_first  <= 1'b0;
            if (cmd == `CL_CMD_PROG_LB2) lock_bit_second <= 1'b0;
            if (cmd == `CL_CMD_PROG_LB3) lock_bit_third  <= 1'b0;
        end
    end

    // refused flag: set wins over clear by a status write
    always_ff @(posedge clk) begin
        if (rst) begin
            refused <= 1'b0;
        end else if (cmd_refused) begin
            refused <= 1'b1;
        end else if (wr_acc && hit_status) begin
            refused <= 1'b0;
        end
    end

    // erase engine
    always_ff @(posedge clk) begin
        if (rst) begin
            state     <= ST_IDLE;
            erase_ptr <= '0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (cmd_ok && cmd == `CL_CMD_ERASE) begin
                        state     <= ST_ERASE;
                        erase_ptr <= '0;
                    end
                end
                ST_ERASE: begin
                    erase_ptr <= erase_ptr + 1'b1;
                    if (&erase_ptr) state <= ST_DONE;
                end
                ST_DONE: state <= ST_IDLE;
            endcase
        end
    end

    // access select is captured once in the first cycle after reset release
    always_ff @(posedge clk) begin
        if (rst) begin
            reset_seen <= 1'b0;
            ea_latch   <= 1'b0;
        end else if (!reset_seen) begin
            reset_seen <= 1'b1;
            ea_latch   <= ea_s2;
        end
    end

    // cpu-side qualifier outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            external_access_latched <= 1'b0;
            table_read_blocked      <= 1'b0;
            external_exec_blocked   <= 1'b0;
            verify_enabled          <= 1'b1;
        end else begin
            external_access_latched <= lvl2_up ? ea_latch : ea_s2;
            table_read_blocked      <= lvl2_up && ext_table;
            external_exec_blocked   <= lvl4 && (fext_s2 || !ctrl[`CL_CTRL_EXT_EXEC]);
            verify_enabled          <= !lvl3_up;
        end
    end
endmodule

/* verification/code_lock_checker.sv */
// port assertions for the code lock block
`timescale 1ns/1ps
module code_lock_checker (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        code_table_read_instruction,
    input wire logic        fetch_external,
    input wire logic        external_access_latched,
    input wire logic        table_read_blocked,
    input wire logic        external_exec_blocked,
    input wire logic        verify_enabled
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire setup_rd = psel && !penable && !pwrite;
    wire sig_wr   = psel && !penable && pwrite && paddr[11:4] == 8'h02 && paddr[1:0] == 2'b00;
    answer_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    err_with_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
    unmapped_err_a: assert property (psel && !penable && paddr == 12'h100 |=> pready && pslverr)
        else $error("unmapped access not refused");
    sig_readonly_a: assert property (sig_wr |=> pready && pslverr) else $error("signature write accepted");
    verify_dark_a: assert property (setup_rd && paddr == 12'h010 && !verify_enabled |=> ##2 pready && prdata == 32'h0)
        else $error("verify data leaked while disabled");
    cpu_dark_a: assert property (setup_rd && paddr == 12'h018 && table_read_blocked |=> ##2 pready && prdata == 32'h0)
        else $error("table read leaked internal code");
    exec_level_a: assert property (external_exec_blocked |-> !verify_enabled) else $error("exec blocked, verify on");
    table_block_a: assert property ((!verify_enabled && code_table_read_instruction && fetch_external)[*5]
        |-> table_read_blocked) else $error("level 3 table read not blocked");
    table_idle_a: assert property ((!code_table_read_instruction)[*4] |-> !table_read_blocked)
        else $error("table block without table read");
    latch_hold_a: assert property ((!verify_enabled)[*3] |-> $stable(external_access_latched))
        else $error("latched access select moved");
    cover property (external_exec_blocked);
    cover property (table_read_blocked && verify_enabled);
    cover property (pready && pslverr);
endmodule
bind code_lock code_lock_checker u_chk (.clk, .rst, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
    .code_table_read_instruction, .fetch_external, .external_access_latched, .table_read_blocked,
    .external_exec_blocked, .verify_enabled);

/* verification/code_programmer.sv */
// apb master model of the external device programmer
`timescale 1ns/1ps
module code_programmer (
    input  wire logic        clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    // request stands until pready is seen at an edge; gives up after 40 edges
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        q = 'x;
        e = 1'bx;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (pready === 1'b1) begin
            q = prdata;
            e = pslverr;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        // released data must not linger as if still valid
        pwdata <= ~d;
    endtask
endmodule

/* verification/code_lock_test.sv */
// self-checking bench for the code lock block
`timescale 1ns/1ps
`include "code_lock_defines.svh"
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin num_errors++; $display("BAD %s exp %0h got %0h", nm, ex, gt); end end
module code_lock_test;
    logic        clk;
    logic        rst;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic        e;
    logic        external_access_select, code_table_read_instruction, fetch_external;
    logic        external_access_latched, table_read_blocked, external_exec_blocked, verify_enabled;
    int          num_errors = 0;
    int          compares = 0;
    int          cycles = 0;
    logic [7:0]  sig [4] = '{`CL_SIG0, `CL_SIG1, `CL_SIG2, `CL_SIG3};

    code_lock u_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .external_access_select, .code_table_read_instruction, .fetch_external, .external_access_latched,
        .table_read_blocked, .external_exec_blocked, .verify_enabled);
    code_programmer u_prog (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic err);
        u_prog.xfer(1'b1, a, d, q, e);
        `CHK("pslverr", err, e)
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] ex, input logic [31:0] m);
        u_prog.xfer(1'b0, a, 32'h0, q, e);
        `CHK("prdata", ex, q & m)
    endtask
    // erase runs for thousands of cycles, so every command waits for busy to drop
    task automatic cmd(input logic [31:0] c);
        int n;
        wr(`CL_OFF_CTRL, c, 1'b0);
        n = 0;
        do begin
            u_prog.xfer(1'b0, `CL_OFF_STATUS, 32'h0, q, e);
            n++;
        end while (q[9] !== 1'b0 && n < 20000);
    endtask
    task automatic prog(input logic [31:0] a, input logic [31:0] d, input logic [31:0] c);
        wr(`CL_OFF_ADDR, a, 1'b0);
        wr(`CL_OFF_DATA, d, 1'b0);
        cmd(c);
    endtask
    task automatic wrap_up();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            num_errors++;
            wrap_up();
        end
    end

    initial begin
        rst = 1'b1;
        external_access_select = 1'b1;
        code_table_read_instruction = 1'b0;
        fetch_external = 1'b0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(`CL_OFF_STATUS, 32'h017, 32'h0F7);
        `CHK("verify_en", 1'b1, verify_enabled)
        for (int i = 0; i < 4; i++) rd(`CL_OFF_SIG_BASE + 12'(4 * i), {24'h0, sig[i]}, 32'hFF);
        wr(`CL_OFF_SIG_BASE, 32'h0, 1'b1);
        rd(`CL_OFF_SIG_BASE, {24'h0, sig[0]}, 32'hFF);
        wr(12'h100, 32'h0, 1'b1);
        cmd(32'h600);
        prog(32'h40, 32'h3C, 32'h100);
        rd(`CL_OFF_VERIFY, 32'h3C, 32'hFF);
        prog(32'h40, 32'h5A, 32'h200);
        rd(`CL_OFF_VERIFY, 32'h99, 32'hFF);
        wr(`CL_OFF_ADDR, 32'h80, 1'b0);
        rd(`CL_OFF_VERIFY, 32'h5A, 32'hFF);
        wr(`CL_OFF_ADDR, 32'h41, 1'b0);
        rd(`CL_OFF_VERIFY, 32'hFF, 32'hFF);
        prog(32'h7FFF, 32'h0F, 32'h200);
        rd(`CL_OFF_VERIFY, 32'h0F, 32'hFF);
        wr(`CL_OFF_CPU_ADDR, 32'h40, 1'b0);
        code_table_read_instruction <= 1'b1;
        fetch_external <= 1'b1;
        external_access_select <= 1'b0;
        repeat (4) @(posedge clk);
        rd(`CL_OFF_CPU_DATA, 32'h3C, 32'hFF);
        `CHK("tbl_blk", 1'b0, table_read_blocked)
        `CHK("ea_live", 1'b0, external_access_latched)
        external_access_select <= 1'b1;
        wr(`CL_OFF_ADDR, 32'h40, 1'b0);
        cmd(32'h301);
        rd(`CL_OFF_STATUS, 32'h026, 32'h0F7);
        external_access_select <= 1'b0;
        repeat (4) @(posedge clk);
        `CHK("ea_held", 1'b1, external_access_latched)
        `CHK("tbl_blk", 1'b1, table_read_blocked)
        rd(`CL_OFF_CPU_DATA, 32'h0, 32'hFF);
        prog(32'h40, 32'h00, 32'h101);
        rd(`CL_OFF_STATUS, 32'h400, 32'h400);
        rd(`CL_OFF_VERIFY, 32'h99, 32'hFF);
        wr(`CL_OFF_STATUS, 32'h0, 1'b0);
        rd(`CL_OFF_STATUS, 32'h0, 32'h400);
        wr(`CL_OFF_CTRL, 32'h0, 1'b0);
        cmd(32'h400);
        rd(`CL_OFF_STATUS, 32'h044, 32'h0F7);
        `CHK("verify_en", 1'b0, verify_enabled)
        `CHK("exec_blk", 1'b0, external_exec_blocked)
        rd(`CL_OFF_VERIFY, 32'h0, 32'hFF);
        cmd(32'h500);
        rd(`CL_OFF_STATUS, 32'h080, 32'h0F7);
        `CHK("exec_blk", 1'b1, external_exec_blocked)
        `CHK("tbl_blk", 1'b1, table_read_blocked)
        cmd(32'h600);
        rd(`CL_OFF_STATUS, 32'h017, 32'h0F7);
        rd(`CL_OFF_VERIFY, 32'hFF, 32'hFF);
        `CHK("verify_en", 1'b1, verify_enabled)
        wrap_up();
    end
endmodule
